// *** core/hpw_pkg.sv ***
// constants for the pwm fault and write lock block
package hpw_pkg;
    localparam int          HPW_NGEN      = 3;
    localparam int          HPW_AW        = 8;
    localparam int          HPW_TBW       = 16;
    // register byte offsets
    localparam logic [7:0]  HPW_OFF_CTRL  = 8'h00;
    localparam logic [7:0]  HPW_OFF_PER   = 8'h04;
    localparam logic [7:0]  HPW_OFF_SEVT  = 8'h08;
    localparam logic [7:0]  HPW_OFF_KEY   = 8'h0c;
    localparam logic [7:0]  HPW_OFF_STAT  = 8'h10;
    localparam logic [7:0]  HPW_GEN_BASE  = 8'h20;
    localparam logic [7:0]  HPW_GEN_STEP  = 8'h10;
    localparam logic [3:0]  HPW_G_DUTY    = 4'h0;
    localparam logic [3:0]  HPW_G_TRIG    = 4'h4;
    localparam logic [3:0]  HPW_G_OCTL    = 4'h8;
    localparam logic [3:0]  HPW_G_FCL     = 4'hc;
    // unlock keys
    localparam logic [15:0] HPW_KEY1      = 16'habcd;
    localparam logic [15:0] HPW_KEY2      = 16'h4321;
    // reset values
    localparam logic [15:0] HPW_PER_RST   = 16'hfff8;
    localparam logic [2:0]  HPW_FLT_RST   = 3'h7;
    localparam logic        HPW_LOCK_RST  = 1'h1;
    // control register fields
    localparam int          HPW_CTL_EN    = 0;
    localparam int          HPW_CTL_SYEN  = 1;
    localparam int          HPW_CTL_SOEN  = 2;
    localparam int          HPW_CTL_SPOL  = 3;
    // output control fields
    localparam int          HPW_OC_HEN    = 0;
    localparam int          HPW_OC_LEN    = 1;
    localparam int          HPW_OC_HSAFE  = 2;
    localparam int          HPW_OC_LSAFE  = 3;
    // fault control fields
    localparam int          HPW_FC_FEN    = 2;
    localparam int          HPW_FC_CLEN   = 3;
    localparam int          HPW_FC_CLR    = 4;
    localparam logic [1:0]  HPW_FM_LATCH  = 2'h0;
    localparam logic [1:0]  HPW_FM_CYC    = 2'h1;
    localparam logic [1:0]  HPW_FM_OFF    = 2'h3;
    // status fields
    localparam int          HPW_ST_CFG    = 3;
    localparam int          HPW_ST_OPEN   = 4;
    localparam int          HPW_ST_CLB    = 5;
    // axi responses
    localparam logic [1:0]  HPW_OKAY      = 2'h0;
    localparam logic [1:0]  HPW_SLVERR    = 2'h2;
endpackage

// *** core/hpw_top.sv ***
// pwm generators with fault handling, adc triggers, sync and a keyed write lock
//
// Overview of operation
// - three generators each drive a high-side and a low-side output.
// - one master time base aligns every generator output.
// - enabled fault or current-limit inputs force outputs to their safe levels.
// - each generator pulses an adc trigger at a programmable count.
// - a special event adc trigger comes from the master time base.
// - external sync input restarts the master time base.
// - sync output pulses at each master period end.
// - per-generator fault inputs plus one class b fault input shut outputs.
// - class b fault input stays owned by this block through reset.
// - after reset the class b fault is enabled and latched.
// - fault mode field accepts writes regardless of class b level.
// - output control and fault control registers are write protected.
// - lock strap at 1 enables protection, 0 disables it.
// - only key 0xabcd then 0x4321 on consecutive accesses unlocks.
// - protected write is accepted only as the next access after unlocking.
// - one unlock grants exactly one protected write.
`timescale 1ns/1ps
module hpw_top
    import hpw_pkg::*;
(
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // write address channel
    input  wire logic [hpw_pkg::HPW_AW-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    // write data channel
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // write response channel
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // read address channel
    input  wire logic [hpw_pkg::HPW_AW-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    // read data channel
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // device option strap
    input  wire logic                          write_lock_cfg_bit,
    // fault and sync inputs
    input  wire logic [hpw_pkg::HPW_NGEN-1:0]  fault_in,
    input  wire logic [hpw_pkg::HPW_NGEN-1:0]  climit_in,
    input  wire logic                          class_b_fault_in,
    input  wire logic                          ext_sync_in,
    // pwm, trigger and sync outputs
    output logic [hpw_pkg::HPW_NGEN-1:0]       gen_high_out,
    output logic [hpw_pkg::HPW_NGEN-1:0]       gen_low_out,
    output logic [hpw_pkg::HPW_NGEN-1:0]       adc_trig_out,
    output logic                               sevt_trig_out,
    output logic                               ext_sync_out
);
    import hpw_pkg::*;

    localparam int NG = HPW_NGEN;
    localparam int NI = 2 * HPW_NGEN + 2;

    typedef enum logic [1:0] {
        HPW_LK_IDLE,
        HPW_LK_KEY1,
        HPW_LK_OPEN
    } hpw_lk_t;

    typedef struct packed {
        logic                          aw_held;
        logic [HPW_AW-1:0]             awaddr;
        logic                          w_held;
        logic [31:0]                   wdata;
        logic [3:0]                    wstrb;
        logic                          awready;
        logic                          wready;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          arready;
        logic                          rvalid;
        logic [31:0]                   rdata;
        logic [1:0]                    rresp;
        logic                          cfg_done;
        logic                          lock_cfg;
        hpw_lk_t                       lk;
        logic [3:0]                    ctrl;
        logic [HPW_TBW-1:0]            period;
        logic [HPW_TBW-1:0]            sevt;
        logic [NG-1:0][HPW_TBW-1:0]    duty;
        logic [NG-1:0][HPW_TBW-1:0]    trig;
        logic [NG-1:0][3:0]            octl;
        logic [NG-1:0][3:0]            fcl;
        logic [NG-1:0]                 flt_lat;
        logic [HPW_TBW-1:0]            tb;
        logic [NI-1:0]                 s1;
        logic [NI-1:0]                 s2;
        logic                          s3;
        logic [NG-1:0]                 hi;
        logic [NG-1:0]                 lo;
        logic [NG-1:0]                 atrig;
        logic                          strig;
        logic                          sync_o;
    } hpw_st_t;

    hpw_st_t st_r;
    hpw_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////
    // address decoding
    function automatic logic gen_hit(input logic [HPW_AW-1:0] a, input int g,
                                     input logic [3:0] off);
        logic [HPW_AW-1:0] base;
        base = HPW_GEN_BASE + HPW_GEN_STEP * g[7:0];
        return a == (base | {4'h0, off});
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = d[7:0];
        end
        if (be[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [HPW_AW-1:0] a);
        logic m;
        m = (a == HPW_OFF_CTRL) || (a == HPW_OFF_PER) || (a == HPW_OFF_SEVT)
            || (a == HPW_OFF_KEY) || (a == HPW_OFF_STAT);
        for (int g = 0; g < NG; g++) begin
            m = m || gen_hit(a, g, HPW_G_DUTY) || gen_hit(a, g, HPW_G_TRIG)
                || gen_hit(a, g, HPW_G_OCTL) || gen_hit(a, g, HPW_G_FCL);
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // next state
    logic              do_wr;
    logic              do_rd;
    logic [NG-1:0]     f_syn;
    logic [NG-1:0]     c_syn;
    logic              clb_syn;
    logic              sync_lvl;
    logic              sync_edge;
    logic              per_end;
    logic              prot_ok;
    logic              prot_hit;
    logic [HPW_AW-1:0] wa;
    logic [31:0]       rd;
    logic [NG-1:0]     src;

    always_comb begin
        st_nxt    = st_r;
        wa        = st_r.awaddr;
        rd        = 32'h0;
        prot_hit  = 1'b0;
        src       = '0;
        // inputs after two flops
        f_syn     = st_r.s2[NG-1:0];
        c_syn     = st_r.s2[2*NG-1:NG];
        clb_syn   = st_r.s2[2*NG];
        sync_lvl  = st_r.s2[2*NG+1] ^ st_r.ctrl[HPW_CTL_SPOL];
        sync_edge = sync_lvl && !(st_r.s3 ^ st_r.ctrl[HPW_CTL_SPOL]);
        st_nxt.s1 = {ext_sync_in, class_b_fault_in, climit_in, fault_in};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2[2*NG+1];
        // strap taken once after reset release
        st_nxt.cfg_done = 1'b1;
        if (!st_r.cfg_done) begin
            st_nxt.lock_cfg = write_lock_cfg_bit;
        end

        // axi write path
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.awaddr  = s_axi_awaddr;
            st_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata  = s_axi_wdata;
            st_nxt.wstrb  = s_axi_wstrb;
            st_nxt.wready = 1'b0;
        end
        do_wr = st_r.aw_held && st_r.w_held && !st_r.bvalid;
        do_rd = s_axi_arvalid && st_r.arready;
        prot_ok = !st_r.lock_cfg
                  || (st_r.lk == HPW_LK_OPEN && !do_rd);
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid  = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready  = 1'b1;
        end
        if (do_wr) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = mapped(wa) ? HPW_OKAY : HPW_SLVERR;
            if (wa == HPW_OFF_CTRL) begin
                st_nxt.ctrl = st_r.wdata[3:0];
            end
            if (wa == HPW_OFF_PER) begin
                st_nxt.period = merge16(st_r.period, st_r.wdata, st_r.wstrb);
            end
            if (wa == HPW_OFF_SEVT) begin
                st_nxt.sevt = merge16(st_r.sevt, st_r.wdata, st_r.wstrb);
            end
            for (int g = 0; g < NG; g++) begin
                if (gen_hit(wa, g, HPW_G_DUTY)) begin
                    st_nxt.duty[g] = merge16(st_r.duty[g], st_r.wdata, st_r.wstrb);
                end
                if (gen_hit(wa, g, HPW_G_TRIG)) begin
                    st_nxt.trig[g] = merge16(st_r.trig[g], st_r.wdata, st_r.wstrb);
                end
                if (gen_hit(wa, g, HPW_G_OCTL)) begin
                    prot_hit = 1'b1;
                    if (prot_ok) begin
                        st_nxt.octl[g] = st_r.wdata[3:0];
                    end
                end
                if (gen_hit(wa, g, HPW_G_FCL)) begin
                    prot_hit = 1'b1;
                    if (prot_ok) begin
                        // mode field taken whatever the class b level
                        st_nxt.fcl[g] = st_r.wdata[3:0];
                        if (st_r.wdata[HPW_FC_CLR] && !clb_syn) begin
                            st_nxt.flt_lat[g] = 1'b0;
                        end
                    end
                end
            end
        end

        // unlock sequencer, matching key writes advance it, any other access resets it
        if (do_wr || do_rd) begin
            st_nxt.lk = HPW_LK_IDLE;
            if (do_wr && !do_rd && wa == HPW_OFF_KEY) begin
                if (st_r.lk == HPW_LK_IDLE && st_r.wdata[15:0] == HPW_KEY1) begin
                    st_nxt.lk = HPW_LK_KEY1;
                end
                if (st_r.lk == HPW_LK_KEY1 && st_r.wdata[15:0] == HPW_KEY2) begin
                    st_nxt.lk = HPW_LK_OPEN;
                end
            end
        end

        // axi read path
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid  = 1'b0;
            st_nxt.arready = 1'b1;
        end
        if (do_rd) begin
            if (s_axi_araddr == HPW_OFF_CTRL) begin
                rd[3:0] = st_r.ctrl;
            end
            if (s_axi_araddr == HPW_OFF_PER) begin
                rd[15:0] = st_r.period;
            end
            if (s_axi_araddr == HPW_OFF_SEVT) begin
                rd[15:0] = st_r.sevt;
            end
            if (s_axi_araddr == HPW_OFF_STAT) begin
                rd[NG-1:0]        = st_r.flt_lat;
                rd[HPW_ST_CFG]    = st_r.lock_cfg;
                rd[HPW_ST_OPEN]   = st_r.lk == HPW_LK_OPEN;
                rd[HPW_ST_CLB]    = clb_syn;
            end
            for (int g = 0; g < NG; g++) begin
                if (gen_hit(s_axi_araddr, g, HPW_G_DUTY)) begin
                    rd[15:0] = st_r.duty[g];
                end
                if (gen_hit(s_axi_araddr, g, HPW_G_TRIG)) begin
                    rd[15:0] = st_r.trig[g];
                end
                if (gen_hit(s_axi_araddr, g, HPW_G_OCTL)) begin
                    rd[3:0] = st_r.octl[g];
                end
                if (gen_hit(s_axi_araddr, g, HPW_G_FCL)) begin
                    rd[3:0] = st_r.fcl[g];
                end
            end
            st_nxt.rdata   = rd;
            st_nxt.rresp   = mapped(s_axi_araddr) ? HPW_OKAY : HPW_SLVERR;
            st_nxt.rvalid  = 1'b1;
            st_nxt.arready = 1'b0;
        end

        ////////////////////////////////////////////////////////////////
        // master time base
        per_end = st_r.tb >= st_r.period;
        if (!st_r.ctrl[HPW_CTL_EN]) begin
            st_nxt.tb = '0;
        end else if (per_end || (st_r.ctrl[HPW_CTL_SYEN] && sync_edge)) begin
            st_nxt.tb = '0;
        end else begin
            st_nxt.tb = st_r.tb + 16'h1;
        end
        st_nxt.strig = st_r.ctrl[HPW_CTL_EN] && st_r.tb == st_r.sevt;
        st_nxt.sync_o = (st_r.ctrl[HPW_CTL_EN] && st_r.ctrl[HPW_CTL_SOEN] && per_end)
                        ^ st_r.ctrl[HPW_CTL_SPOL];

        // generators, faults and safe states
        for (int g = 0; g < NG; g++) begin
            src[g] = clb_syn
                     || (st_r.fcl[g][HPW_FC_FEN] && f_syn[g])
                     || (st_r.fcl[g][HPW_FC_CLEN] && c_syn[g]);
            if (st_r.fcl[g][1:0] == HPW_FM_OFF) begin
                st_nxt.flt_lat[g] = 1'b0;
            end else begin
                if (st_r.fcl[g][1:0] == HPW_FM_CYC && per_end && !src[g]) begin
                    st_nxt.flt_lat[g] = 1'b0;
                end
                if (src[g]) begin
                    st_nxt.flt_lat[g] = 1'b1;
                end
            end
            if (st_r.flt_lat[g]) begin
                st_nxt.hi[g] = st_r.octl[g][HPW_OC_HSAFE];
                st_nxt.lo[g] = st_r.octl[g][HPW_OC_LSAFE];
            end else begin
                st_nxt.hi[g] = st_r.ctrl[HPW_CTL_EN] && st_r.octl[g][HPW_OC_HEN]
                               && st_r.tb < st_r.duty[g];
                st_nxt.lo[g] = st_r.ctrl[HPW_CTL_EN] && st_r.octl[g][HPW_OC_LEN]
                               && st_r.tb >= st_r.duty[g];
            end
            st_nxt.atrig[g] = st_r.ctrl[HPW_CTL_EN] && st_r.tb == st_r.trig[g];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r          <= '0;
            st_r.awready  <= 1'b1;
            st_r.wready   <= 1'b1;
            st_r.arready  <= 1'b1;
            st_r.lock_cfg <= HPW_LOCK_RST;
            st_r.period   <= HPW_PER_RST;
            st_r.flt_lat  <= HPW_FLT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign gen_high_out  = st_r.hi;
    assign gen_low_out   = st_r.lo;
    assign adc_trig_out  = st_r.atrig;
    assign sevt_trig_out = st_r.strig;
    assign ext_sync_out  = st_r.sync_o;
endmodule

// *** testbench/hpw_chk_asserts.sv ***
// port-level checker for the pwm fault and write lock block
`timescale 1ns/1ps
module hpw_chk
    import hpw_pkg::*;
(
    // clock and reset
    input wire logic                         aclk,
    input wire logic                         aresetn,
    // register bus
    input wire logic                         s_axi_awvalid,
    input wire logic                         s_axi_awready,
    input wire logic                         s_axi_wvalid,
    input wire logic                         s_axi_wready,
    input wire logic [1:0]                   s_axi_bresp,
    input wire logic                         s_axi_bvalid,
    input wire logic                         s_axi_bready,
    input wire logic                         s_axi_arvalid,
    input wire logic                         s_axi_arready,
    input wire logic [31:0]                  s_axi_rdata,
    input wire logic [1:0]                   s_axi_rresp,
    input wire logic                         s_axi_rvalid,
    input wire logic                         s_axi_rready,
    // pwm side
    input wire logic [hpw_pkg::HPW_NGEN-1:0] gen_high_out,
    input wire logic [hpw_pkg::HPW_NGEN-1:0] gen_low_out,
    input wire logic [hpw_pkg::HPW_NGEN-1:0] adc_trig_out,
    input wire logic                         sevt_trig_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst_quiet;
        disable iff (1'b0) !aresetn |=> gen_high_out == '0 && gen_low_out == '0
            && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    property p_no_overlap;
        (gen_high_out & gen_low_out) == '0;
    endproperty
    property p_trig_pulse;
        adc_trig_out != '0 |=> (adc_trig_out & $past(adc_trig_out)) == '0;
    endproperty
    property p_sevt_pulse;
        $rose(sevt_trig_out) |=> !sevt_trig_out;
    endproperty
    property p_b_timing;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_timing;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rst_quiet:  assert property (p_rst_quiet)  else $error("outputs active after reset");
    a_no_overlap: assert property (p_no_overlap) else $error("high and low both on");
    a_trig_pulse: assert property (p_trig_pulse) else $error("adc trigger too long");
    a_sevt_pulse: assert property (p_sevt_pulse) else $error("special trigger too long");
    a_b_timing:   assert property (p_b_timing)   else $error("write response late");
    a_b_hold:     assert property (p_b_hold)     else $error("write response dropped");
    a_r_timing:   assert property (p_r_timing)   else $error("read answer late");
    a_r_hold:     assert property (p_r_hold)     else $error("read data changed");
    c_write:  cover property (s_axi_bvalid && s_axi_bready);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == HPW_SLVERR);
    c_sevt:   cover property (sevt_trig_out);
endmodule
bind hpw_top hpw_chk i_hpw_chk (.*);

// *** testbench/hpw_pwr_model.sv ***
// power stage, fault sensors and adc seen from the pwm outputs
`timescale 1ns/1ps
module hpw_pwr_model
    import hpw_pkg::*;
(
    // pwm side
    input wire logic                         aclk,
    input wire logic [hpw_pkg::HPW_NGEN-1:0] gen_high_out,
    input wire logic [hpw_pkg::HPW_NGEN-1:0] gen_low_out,
    input wire logic [hpw_pkg::HPW_NGEN-1:0] adc_trig_out,
    input wire logic                         sevt_trig_out,
    input wire logic                         ext_sync_out,
    // sensor side
    output logic [hpw_pkg::HPW_NGEN-1:0]     fault_in,
    output logic [hpw_pkg::HPW_NGEN-1:0]     climit_in,
    output logic                             class_b_fault_in,
    output logic                             ext_sync_in
);
    int hi_cnt, lo_cnt, trig_cnt, sevt_cnt, sync_cnt;
    // class b pin held low by the pull-down unless a fault is injected
    initial begin
        fault_in = '0;
        climit_in = '0;
        class_b_fault_in = 1'b0;
        ext_sync_in = 1'b0;
    end
    task automatic drive(input logic [2:0] f, input logic cb);
        @(posedge aclk);
        fault_in <= f;
        class_b_fault_in <= cb;
    endtask
    // counts generator 0 and the adc events over n cycles
    task automatic observe(input int n);
        hi_cnt = 0;
        lo_cnt = 0;
        trig_cnt = 0;
        sevt_cnt = 0;
        sync_cnt = 0;
        repeat (n) begin
            @(posedge aclk);
            hi_cnt += int'(gen_high_out[0]);
            lo_cnt += int'(gen_low_out[0]);
            trig_cnt += int'(adc_trig_out[0]);
            sevt_cnt += int'(sevt_trig_out);
            sync_cnt += int'(ext_sync_out);
        end
    endtask
endmodule

// *** testbench/test_pwm_fault_and_write_lock.sv ***
// register-level tests of the write lock, faults and pwm timing
`timescale 1ns/1ps
module test_pwm_fault_and_write_lock;
    import hpw_pkg::*;
    localparam logic [7:0] DUTY0 = HPW_GEN_BASE + {4'h0, HPW_G_DUTY};
    localparam logic [7:0] TRIG0 = HPW_GEN_BASE + {4'h0, HPW_G_TRIG};
    localparam logic [7:0] OCTL0 = HPW_GEN_BASE + {4'h0, HPW_G_OCTL};
    localparam logic [7:0] FCL0  = HPW_GEN_BASE + {4'h0, HPW_G_FCL};
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_data;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [2:0]  fault_in, climit_in, gen_high_out, gen_low_out, adc_trig_out;
    logic        class_b_fault_in, ext_sync_in, sevt_trig_out, ext_sync_out;
    int          err_total = 0, num_checks = 0;
    always #25 aclk = ~aclk;
    hpw_top i_hpw_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .write_lock_cfg_bit(1'b1), .fault_in(fault_in),
        .climit_in(climit_in), .class_b_fault_in(class_b_fault_in),
        .ext_sync_in(ext_sync_in), .gen_high_out(gen_high_out), .gen_low_out(gen_low_out),
        .adc_trig_out(adc_trig_out), .sevt_trig_out(sevt_trig_out),
        .ext_sync_out(ext_sync_out));
    hpw_pwr_model i_hpw_pwr_model (.aclk(aclk), .gen_high_out(gen_high_out),
        .gen_low_out(gen_low_out), .adc_trig_out(adc_trig_out),
        .sevt_trig_out(sevt_trig_out), .ext_sync_out(ext_sync_out), .fault_in(fault_in),
        .climit_in(climit_in), .class_b_fault_in(class_b_fault_in),
        .ext_sync_in(ext_sync_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", nm, e, s);
            err_total++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, HPW_OKAY}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
        rd(a);
        chk(nm, e, rd_data & m);
    endtask
    task automatic prot(input logic [7:0] a, input logic [31:0] d);
        wr(HPW_OFF_KEY, {16'h0, HPW_KEY1});
        wr(HPW_OFF_KEY, {16'h0, HPW_KEY2});
        wr(a, d);
    endtask
    task automatic run(input int hi, input int lo);
        i_hpw_pwr_model.observe(20);
        chk("high count", hi, i_hpw_pwr_model.hi_cnt);
        chk("low count", lo, i_hpw_pwr_model.lo_cnt);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rc("status after reset", HPW_OFF_STAT, 32'h3f, 32'h0f);
        rd(8'h14);
        chk("unmapped resp", {30'h0, HPW_SLVERR}, {30'h0, rd_resp});
        chk("unmapped data", 32'h0, rd_data);
        wr(OCTL0, 32'h3);
        rc("locked octl", OCTL0, 32'hf, 32'h0);
        wr(HPW_OFF_KEY, {16'h0, HPW_KEY1});
        wr(HPW_OFF_KEY, 32'h1234);
        wr(OCTL0, 32'h3);
        rc("key mismatch", OCTL0, 32'hf, 32'h0);
        wr(HPW_OFF_KEY, {16'h0, HPW_KEY1});
        rd(HPW_OFF_PER);
        wr(HPW_OFF_KEY, {16'h0, HPW_KEY2});
        wr(OCTL0, 32'h3);
        rc("intervening read", OCTL0, 32'hf, 32'h0);
        prot(OCTL0, 32'h3);
        rc("unlocked octl", OCTL0, 32'hf, 32'h3);
        wr(OCTL0, 32'h0);
        rc("single grant", OCTL0, 32'hf, 32'h3);
        i_hpw_pwr_model.drive(3'h0, 1'b1);
        prot(FCL0, 32'h1);
        rc("mode field", FCL0, 32'h3, 32'h1);
        i_hpw_pwr_model.drive(3'h0, 1'b0);
        prot(FCL0, 32'h14);
        rc("latch cleared", HPW_OFF_STAT, 32'h1, 32'h0);
        wr(HPW_OFF_PER, 32'h9);
        wr(DUTY0, 32'h4);
        wr(TRIG0, 32'h2);
        wr(HPW_OFF_SEVT, 32'h5);
        wr(HPW_OFF_CTRL, 32'h5);
        run(8, 12);
        chk("adc triggers", 2, i_hpw_pwr_model.trig_cnt);
        chk("special triggers", 2, i_hpw_pwr_model.sevt_cnt);
        chk("sync pulses", 2, i_hpw_pwr_model.sync_cnt);
        i_hpw_pwr_model.drive(3'h1, 1'b0);
        repeat (6) @(posedge aclk);
        i_hpw_pwr_model.drive(3'h0, 1'b0);
        run(0, 0);
        prot(FCL0, 32'h14);
        run(8, 12);
        i_hpw_pwr_model.drive(3'h0, 1'b1);
        repeat (6) @(posedge aclk);
        rc("class b status", HPW_OFF_STAT, 32'h21, 32'h21);
        run(0, 0);
        stop_test();
    end
endmodule
